// *** src/fault_mask_unlock_regs.sv ***
// Fault mask, suppression timer, unlock key and calibration control bank.
// Assumes a serial engine on clk_sys hands over decoded byte accesses.
// Function
// - Saturation faults suppressed for stored count times half a millisecond after laser on.
// - A stored count of zero gives no suppression at all.
// - Protected registers are reachable only after a valid key is presented.
// - Suppression, mask and key setting bytes survive resets and power cycles.
// - Interrupt asserts only when global enable high and irq mask bit low.
// - Mask bit 6 enables the power-on hour meter.
// - Mask bits 3..0 block saturation, tx power, bias high and diode faults.
// - Key setting compared with four-byte entry field; all four bytes match.
// - Matching key opens only the high protected serial address; the low one is never decoded.
// - New key setting takes effect only after power-on or warm reset.
// - Key setting spans four bytes, highest address most significant.
// - Calibration control zero is volatile and resets to all zeros.
// - DAC calibration mode bypasses the temperature compensation tables.
// - Compare disable stops new comparator faults; set flags stay until cleared.
`timescale 1ns/10ps
module fault_mask_unlock_regs
  import fault_mask_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES
)
(
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       warm_reset,
  input  wire logic       nv_erase,
  input  wire logic       acc_wr,
  input  wire logic       acc_rd,
  input  wire logic [7:0] acc_dev,
  input  wire logic [7:0] acc_addr,
  input  wire logic [7:0] acc_wdata,
  input  wire logic       laser_on,
  input  wire logic       global_irq_enable,
  input  wire logic       irq_pending,
  input  wire logic       sat_fault_raw,
  input  wire logic       tx_fault_raw,
  input  wire logic       bias_fault_raw,
  input  wire logic       diode_fault_raw,
  input  wire logic       flag_clear,
  output logic [7:0]      acc_rdata,
  output logic            acc_rvalid,
  output logic            irq_n,
  output logic [3:0]      fault_flags,
  output logic            sat_suppress,
  output logic            unlocked,
  output logic            hour_meter_enable,
  output logic            lut_bypass,
  output logic            single_channel_fault_mode,
  output logic            nv_write_inhibit,
  output logic            force_outputs
);

  // ****************************************************************
  // Non-volatile store
  // ****************************************************************
  nv_if nv ();

  nv_store u_store (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .nv      (nv.store)
  );

  logic [7:0]  fault_suppress_time;
  logic [7:0]  fault_mask_reg;
  logic [31:0] unlock_key_setting;

  // Highest byte address carries the most significant key byte.
  assign fault_suppress_time = nv.image[NV_IDX_SUPP];
  assign fault_mask_reg      = nv.image[NV_IDX_MASK];
  assign unlock_key_setting  = {nv.image[5], nv.image[4], nv.image[3], nv.image[2]};

  // Returns true for an access to one of the two protected devices.
  function automatic logic is_prot(input logic [7:0] dev);
    return (dev == DEV_PROT_LOW) || (dev == DEV_PROT_HIGH);
  endfunction

  // ****************************************************************
  // Key entry, reference and access state
  // ****************************************************************
  logic [31:0] key_entry_reg, key_entry_next;
  logic [31:0] key_ref_reg, key_ref_next;
  logic        ref_load_reg, ref_load_next;
  logic        unlock_reg, unlock_next;
  logic [7:0]  cal0_reg, cal0_next;
  logic        prot_wr;

  // The reference is caught one edge after reset release, never under reset.
  always_comb
  begin
    key_entry_next = key_entry_reg;
    key_ref_next   = key_ref_reg;
    ref_load_next  = 1'b0;
    if (acc_wr && acc_dev == DEV_USER && acc_addr >= OFS_KEY_ENT0 && acc_addr <= OFS_KEY_ENT3)
      key_entry_next[8*(acc_addr - OFS_KEY_ENT0) +: 8] = acc_wdata;
    if (ref_load_reg)
      key_ref_next = unlock_key_setting;
    if (warm_reset)
      ref_load_next = 1'b1;
    unlock_next = (key_entry_reg == key_ref_reg) && !ref_load_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      key_entry_reg <= KEY_RESET;
      key_ref_reg   <= KEY_RESET;
      ref_load_reg  <= 1'b1;
      unlock_reg    <= 1'b0;
    end
    else if (clk_en)
    begin
      key_entry_reg <= key_entry_next;
      key_ref_reg   <= key_ref_next;
      ref_load_reg  <= ref_load_next;
      unlock_reg    <= unlock_next;
    end
  end

  // Protected writes only go through while the key matches.
  assign prot_wr = acc_wr && unlock_reg && (acc_dev == DEV_PROT_HIGH);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_comb
  begin
    nv.wr     = 1'b0;
    nv.idx    = NV_IDX_SUPP;
    nv.wdata  = acc_wdata;
    nv.erase  = nv_erase;
    cal0_next = cal0_reg;
    if (prot_wr)
    begin
      if (acc_addr == OFS_SUPPRESS)
        nv.wr = 1'b1;
      else if (acc_addr == OFS_FAULT_MSK)
      begin
        nv.wr    = 1'b1;
        nv.idx   = NV_IDX_MASK;
        nv.wdata = acc_wdata & MSK_RW_BITS;
      end
      else if (acc_addr >= OFS_KEY_SET0 && acc_addr <= OFS_KEY_SET3)
      begin
        nv.wr  = 1'b1;
        nv.idx = NV_IDX_KEY0 + 3'(acc_addr - OFS_KEY_SET0);
      end
      else if (acc_addr == OFS_CAL0)
        cal0_next = acc_wdata & CAL_RW_BITS;
    end
  end

  // Calibration control is volatile and clears on reset_n; warm_reset leaves it unchanged.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      cal0_reg <= BYTE_RESET;
    else if (clk_en)
      cal0_reg <= cal0_next;
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  logic [7:0] rdata_next;

  // Locked or unmapped reads return zero rather than stale data.
  always_comb
  begin
    rdata_next = 8'h00;
    if (acc_dev == DEV_PROT_HIGH && unlock_reg)
    begin
      if (acc_addr == OFS_SUPPRESS)
        rdata_next = fault_suppress_time;
      else if (acc_addr == OFS_FAULT_MSK)
        rdata_next = fault_mask_reg;
      else if (acc_addr >= OFS_KEY_SET0 && acc_addr <= OFS_KEY_SET3)
        rdata_next = nv.image[NV_IDX_KEY0 + 3'(acc_addr - OFS_KEY_SET0)];
      else if (acc_addr == OFS_CAL0)
        rdata_next = cal0_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      acc_rdata  <= 8'h00;
      acc_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      acc_rdata  <= acc_rd ? rdata_next : acc_rdata;
      acc_rvalid <= acc_rd;
    end
  end

  // ****************************************************************
  // Saturation fault suppression timer
  // ****************************************************************
  suppress_state_e sup_reg, sup_next;
  logic [15:0]     pre_reg, pre_next;
  logic [7:0]      steps_reg, steps_next;
  logic            laser_d_reg;
  logic            laser_rise;

  assign laser_rise = laser_on && !laser_d_reg;

  // Counts whole half-millisecond steps; zero never enters the active state.
  always_comb
  begin
    sup_next   = sup_reg;
    pre_next   = pre_reg;
    steps_next = steps_reg;
    case (sup_reg)
      SUP_IDLE:
      begin
        if (laser_rise && fault_suppress_time != 8'h00)
        begin
          sup_next   = SUP_ACTIVE;
          pre_next   = 16'(STEP_CYC - 1);
          steps_next = fault_suppress_time;
        end
      end
      SUP_ACTIVE:
      begin
        if (!laser_on)
          sup_next = SUP_IDLE;
        else if (pre_reg != 16'h0000)
          pre_next = pre_reg - 16'h0001;
        else if (steps_reg == 8'h01)
          sup_next = SUP_IDLE;
        else
        begin
          pre_next   = 16'(STEP_CYC - 1);
          steps_next = steps_reg - 8'h01;
        end
      end
      default: sup_next = SUP_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sup_reg     <= SUP_IDLE;
      pre_reg     <= 16'h0000;
      steps_reg   <= 8'h00;
      laser_d_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sup_reg     <= sup_next;
      pre_reg     <= pre_next;
      steps_reg   <= steps_next;
      laser_d_reg <= laser_on;
    end
  end

  // ****************************************************************
  // Fault flags, interrupt and control outputs
  // ****************************************************************
  logic [3:0] flags_next;
  logic [3:0] fault_hit;

  // The comparator faults (tx power, bias) cannot set while compare is disabled.
  always_comb
  begin
    fault_hit[MSK_SAT]   = sat_fault_raw && !fault_mask_reg[MSK_SAT] && sup_reg == SUP_IDLE;
    fault_hit[MSK_TX]    = tx_fault_raw && !fault_mask_reg[MSK_TX] && !cal0_reg[CAL_FDIS];
    fault_hit[MSK_BIAS]  = bias_fault_raw && !fault_mask_reg[MSK_BIAS] && !cal0_reg[CAL_FDIS];
    fault_hit[MSK_DIODE] = diode_fault_raw && !fault_mask_reg[MSK_DIODE];
    // A new fault wins over a clear in the same cycle.
    flags_next = (flag_clear ? 4'h0 : fault_flags) | fault_hit;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      fault_flags               <= 4'h0;
      irq_n                     <= 1'b1;
      sat_suppress              <= 1'b0;
      unlocked                  <= 1'b0;
      hour_meter_enable         <= 1'b0;
      lut_bypass                <= 1'b0;
      single_channel_fault_mode <= 1'b0;
      nv_write_inhibit          <= 1'b0;
      force_outputs             <= 1'b0;
    end
    else if (clk_en)
    begin
      fault_flags               <= flags_next;
      irq_n                     <= !(irq_pending && global_irq_enable
                                     && !fault_mask_reg[MSK_IRQ]);
      sat_suppress              <= sup_next == SUP_ACTIVE;
      unlocked                  <= unlock_next;
      hour_meter_enable         <= fault_mask_reg[MSK_HOUR];
      lut_bypass                <= cal0_next[CAL_DACC];
      single_channel_fault_mode <= cal0_next[CAL_SPIN];
      nv_write_inhibit          <= cal0_next[CAL_WINH];
      force_outputs             <= cal0_next[CAL_FORCE];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_irq_mask_blocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && fault_mask_reg[MSK_IRQ] |=> irq_n)
    else $error("interrupt asserted while mask bit set");

  a_locked_no_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    acc_wr && !unlock_reg |-> !nv.wr)
    else $error("protected store written while locked");

  a_zero_no_suppress: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && laser_rise && fault_suppress_time == 8'h00 && sup_reg == SUP_IDLE
    |=> sup_reg == SUP_IDLE)
    else $error("suppression started with zero count");

  a_suppress_starts: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && laser_rise && fault_suppress_time != 8'h00 && sup_reg == SUP_IDLE
    |=> sup_reg == SUP_ACTIVE && steps_reg == $past(fault_suppress_time))
    else $error("suppression did not load its count");

  a_sat_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && sup_reg == SUP_ACTIVE && !flag_clear |=> fault_flags[MSK_SAT]
    == $past(fault_flags[MSK_SAT]))
    else $error("saturation flag set during suppression");

  a_fdis_no_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && cal0_reg[CAL_FDIS] && !fault_flags[MSK_TX] |=> !fault_flags[MSK_TX])
    else $error("tx flag set while compare disabled");

  a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && flag_clear && diode_fault_raw && !fault_mask_reg[MSK_DIODE]
    |=> fault_flags[MSK_DIODE])
    else $error("diode fault lost against clear");

  a_cal_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cal0_reg & ~CAL_RW_BITS) == 8'h00)
    else $error("reserved calibration bit set");

  a_ref_after_warm: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && !ref_load_reg && !warm_reset |=> $stable(key_ref_reg))
    else $error("key reference changed without reset");

endmodule // fault_mask_unlock_regs

// *** pkg/fault_mask_pkg.sv ***
// Package for the fault mask and unlock register bank.
// Assumes a 20 MHz system clock and byte accesses from the serial engine.
package fault_mask_pkg;

  // ****************************************************************
  // Serial device addresses and byte offsets
  // ****************************************************************
  localparam logic [7:0] DEV_USER      = 8'hA2;
  localparam logic [7:0] DEV_PROT_LOW  = 8'hA4;
  localparam logic [7:0] DEV_PROT_HIGH = 8'hA6;
  localparam logic [7:0] OFS_SUPPRESS  = 8'h0A;
  localparam logic [7:0] OFS_FAULT_MSK = 8'h0B;
  localparam logic [7:0] OFS_KEY_SET0  = 8'h0C;
  localparam logic [7:0] OFS_KEY_SET3  = 8'h0F;
  localparam logic [7:0] OFS_CAL0      = 8'h10;
  localparam logic [7:0] OFS_KEY_ENT0  = 8'h7B;
  localparam logic [7:0] OFS_KEY_ENT3  = 8'h7E;

  // ****************************************************************
  // Non-volatile image layout and reset values
  // ****************************************************************
  localparam int         NV_BYTES      = 6;
  localparam logic [2:0] NV_IDX_SUPP   = 3'h0;
  localparam logic [2:0] NV_IDX_MASK   = 3'h1;
  localparam logic [2:0] NV_IDX_KEY0   = 3'h2;
  localparam logic [7:0] BYTE_RESET    = 8'h00;
  localparam logic [31:0] KEY_RESET    = 32'h0000_0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MSK_IRQ   = 7;
  localparam int MSK_HOUR  = 6;
  localparam int MSK_SAT   = 3;
  localparam int MSK_TX    = 2;
  localparam int MSK_BIAS  = 1;
  localparam int MSK_DIODE = 0;
  localparam logic [7:0] MSK_RW_BITS = 8'hCF;
  localparam int CAL_FDIS  = 6;
  localparam int CAL_SPIN  = 5;
  localparam int CAL_WINH  = 4;
  localparam int CAL_DACC  = 3;
  localparam int CAL_FORCE = 0;
  localparam logic [7:0] CAL_RW_BITS = 8'h79;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 50;
  localparam int SUPPRESS_STEP_US = 500;
  localparam int STEP_CYCLES      = SUPPRESS_STEP_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [0:0] {SUP_IDLE = 1'b0, SUP_ACTIVE = 1'b1} suppress_state_e;

endpackage

// *** pkg/nv_if.sv ***
// Interface between the register bank and its non-volatile byte store.
// Assumes both ends run on clk_sys.
`timescale 1ns/10ps
interface nv_if;
  import fault_mask_pkg::*;
  logic                          wr;
  logic [2:0]                    idx;
  logic [7:0]                    wdata;
  logic                          erase;
  logic [NV_BYTES-1:0][7:0]      image;
  modport store (input wr, input idx, input wdata, input erase, output image);
  modport user  (output wr, output idx, output wdata, output erase, input image);
endinterface

// *** src/nv_store.sv ***
// Non-volatile byte store behind the protected registers.
// Assumes writes come already qualified by the unlock check.
`timescale 1ns/10ps
module nv_store
  import fault_mask_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic clk_en,
  nv_if.store       nv
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] mem_reg [NV_BYTES];
  logic [7:0] mem_next [NV_BYTES];

  // No reset here on purpose: contents survive warm and power-on resets.
  always_comb
  begin
    for (int i = 0; i < NV_BYTES; i++)
    begin
      mem_next[i] = mem_reg[i];
      if (nv.erase)
        mem_next[i] = BYTE_RESET;
      else if (nv.wr && (nv.idx == i[2:0]))
        mem_next[i] = nv.wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (clk_en)
      mem_reg <= mem_next;
  end

  // Flatten the array for the reader.
  genvar g;
  generate
    for (g = 0; g < NV_BYTES; g++)
    begin : g_img
      assign nv.image[g] = mem_reg[g];
    end
  endgenerate

endmodule // nv_store

// *** sim/host_model.sv ***
// Host side of the register bank: byte writes and reads on the access strobes.
// Assumes the bank samples strobes on the rising edge of clk_sys.
`timescale 1ns/10ps
module host_model
  import fault_mask_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] acc_rdata,
  input  wire logic       acc_rvalid,
  output logic            acc_wr,
  output logic            acc_rd,
  output logic [7:0]      acc_dev,
  output logic [7:0]      acc_addr,
  output logic [7:0]      acc_wdata
);
  // ********************************************
  // Idle bus
  // ********************************************
  // Strobes start low so nothing is taken during reset.
  initial
  begin
    acc_wr    = 1'b0;
    acc_rd    = 1'b0;
    acc_dev   = 8'h00;
    acc_addr  = 8'h00;
    acc_wdata = 8'h00;
  end

  // ********************************************
  // Access tasks
  // ********************************************
  // Write one byte; released lines show the inverse so stale values never pass.
  task automatic wr_byte(input logic [7:0] dev, input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == OFS_FAULT_MSK) d = data & MSK_RW_BITS;
    @(posedge clk_sys);
    acc_wr    <= 1'b1;
    acc_dev   <= dev;
    acc_addr  <= addr;
    acc_wdata <= d;
    @(posedge clk_sys);
    acc_wr    <= 1'b0;
    acc_dev   <= ~dev;
    acc_addr  <= ~addr;
    acc_wdata <= ~d;
  endtask

  // Read one byte; the answer is taken at the edge where acc_rvalid is seen high.
  task automatic rd_byte(input logic [7:0] dev, input logic [7:0] addr, output logic [7:0] data);
    data = 8'hXX;
    @(posedge clk_sys);
    acc_rd   <= 1'b1;
    acc_dev  <= dev;
    acc_addr <= addr;
    @(posedge clk_sys);
    acc_rd   <= 1'b0;
    acc_dev  <= ~dev;
    acc_addr <= ~addr;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      if (acc_rvalid === 1'b1)
      begin
        data = acc_rdata;
        break;
      end
    end
  endtask
endmodule // host_model

// *** sim/tb_fault_mask_unlock_regs.sv ***
// Self-checking bench for the fault mask and unlock register bank.
// Assumes the host model drives the access strobes; short suppression step.
`timescale 1ns/10ps
module tb_fault_mask_unlock_regs;
  import fault_mask_pkg::*;
  localparam int STEP_SIM = 4;
  localparam int TIMEOUT  = 6000;
  logic       clk_sys, reset_n, warm_reset, nv_erase, laser_on, flag_clear;
  logic       global_irq_enable, irq_pending, acc_wr, acc_rd, acc_rvalid, irq_n;
  logic       sat_suppress, unlocked, hour_meter_enable, lut_bypass;
  logic       single_channel_fault_mode, nv_write_inhibit, force_outputs, clk_en;
  logic [3:0] fault_raw, fault_flags;
  logic [7:0] acc_dev, acc_addr, acc_wdata, acc_rdata, d;
  int         err_total, checks, cyc, n;

  fault_mask_unlock_regs #(.STEP_CYC(STEP_SIM)) i_fault_mask_unlock_regs (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .warm_reset(warm_reset),
    .nv_erase(nv_erase), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_dev(acc_dev),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .laser_on(laser_on),
    .global_irq_enable(global_irq_enable), .irq_pending(irq_pending),
    .sat_fault_raw(fault_raw[3]), .tx_fault_raw(fault_raw[2]),
    .bias_fault_raw(fault_raw[1]), .diode_fault_raw(fault_raw[0]),
    .flag_clear(flag_clear), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .irq_n(irq_n), .fault_flags(fault_flags), .sat_suppress(sat_suppress),
    .unlocked(unlocked), .hour_meter_enable(hour_meter_enable), .lut_bypass(lut_bypass),
    .single_channel_fault_mode(single_channel_fault_mode),
    .nv_write_inhibit(nv_write_inhibit), .force_outputs(force_outputs));

  host_model i_host_model (
    .clk_sys(clk_sys), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .acc_wr(acc_wr),
    .acc_rd(acc_rd), .acc_dev(acc_dev), .acc_addr(acc_addr), .acc_wdata(acc_wdata));

  // ********************************************
  // Clock, timeout and reporting
  // ********************************************
  // A 50 ns clock for the 20 MHz system rate.
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  // A hang ends the run as a failure rather than stalling it forever.
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == TIMEOUT)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  // ********************************************
  // Helpers
  // ********************************************
  // Protected write and read at the high serial address.
  task automatic wp(input logic [7:0] a, input logic [7:0] v);
    i_host_model.wr_byte(DEV_PROT_HIGH, a, v);
  endtask

  task automatic rp(input logic [7:0] a, input logic [7:0] exp);
    i_host_model.rd_byte(DEV_PROT_HIGH, a, d);
    chk_byte(d, exp);
  endtask

  task automatic enter_key(input logic [31:0] k);
    for (int i = 0; i < 4; i++) i_host_model.wr_byte(DEV_USER, OFS_KEY_ENT0 + 8'(i), k[8*i+:8]);
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic pulse_clear();
    @(posedge clk_sys) flag_clear <= 1'b1;
    @(posedge clk_sys) flag_clear <= 1'b0;
  endtask

  // ********************************************
  // Main sequence
  // ********************************************
  // The key starts at zero, so the bank comes up open after erase and reset.
  initial
  begin
    {reset_n, warm_reset, laser_on, flag_clear, global_irq_enable, irq_pending} = 6'h00;
    clk_en = 1'b1;
    {nv_erase, fault_raw, err_total, checks, cyc} = 0;
    nv_erase = 1'b1;
    repeat (2) @(posedge clk_sys);
    nv_erase <= 1'b0;
    reset_n  <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_bit(unlocked, 1'b1);
    chk_bit(irq_n, 1'b1);
    for (int i = 0; i < 7; i++) rp(OFS_SUPPRESS + 8'(i), 8'h00);
    wp(OFS_CAL0, 8'hFF);
    rp(OFS_CAL0, CAL_RW_BITS);
    chk_byte({4'h0, lut_bypass, single_channel_fault_mode, nv_write_inhibit,
      force_outputs}, 8'h0F);
    wp(OFS_CAL0, 8'h00);
    rp(OFS_FAULT_MSK, 8'h00);
    // Every pairing of interrupt mask and global enable with a pending source.
    irq_pending <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wp(OFS_FAULT_MSK, {k[1], 7'h40});
      global_irq_enable <= k[0];
      repeat (3) @(posedge clk_sys);
      chk_bit(irq_n, !(k[0] && !k[1]));
      chk_bit(hour_meter_enable, 1'b1);
    end
    wp(OFS_FAULT_MSK, 8'hFF);
    rp(OFS_FAULT_MSK, 8'hCF);
    fault_raw <= 4'hF;
    repeat (3) @(posedge clk_sys);
    chk_byte({4'h0, fault_flags}, 8'h00);
    // Open one fault at a time to prove each mask bit's position.
    for (int b = 0; b < 4; b++)
    begin
      fault_raw <= 4'h0;
      pulse_clear();
      wp(OFS_FAULT_MSK, 8'h0F & ~(8'h01 << b));
      fault_raw <= 4'hF;
      repeat (3) @(posedge clk_sys);
      chk_byte({4'h0, fault_flags}, 8'h01 << b);
    end
    chk_bit(hour_meter_enable, 1'b0);
    fault_raw <= 4'h6;
    wp(OFS_FAULT_MSK, 8'h00);
    wp(OFS_CAL0, 8'h40);
    rp(OFS_FAULT_MSK, 8'h00);
    chk_byte({4'h0, fault_flags}, 8'h0E);
    fault_raw <= 4'h0;
    pulse_clear();
    fault_raw <= 4'hF;
    repeat (3) @(posedge clk_sys);
    chk_byte({4'h0, fault_flags}, 8'h09);
    fault_raw <= 4'h0;
    wp(OFS_CAL0, 8'h00);
    pulse_clear();
    // Suppression: none for a zero count, count times step otherwise.
    for (int c = 0; c < 4; c += 3)
    begin
      wp(OFS_SUPPRESS, 8'(c));
      n = 0;
      laser_on  <= 1'b1;
      // The fault follows the turn-on edge by one cycle, since the timer starts at that edge.
      for (int i = 0; i < 40; i++)
      begin
        @(posedge clk_sys);
        if (i == 0) fault_raw <= 4'h8;
        if (i == 8) fault_raw <= 4'h0;
        if (sat_suppress === 1'b1) n++;
      end
      chk_byte(8'(n), 8'(c * STEP_SIM));
      chk_bit(fault_flags[3], c == 0);
      laser_on <= 1'b0;
      pulse_clear();
    end
    // Key setting, warm reset, lock and entry.
    wp(OFS_FAULT_MSK, 8'h41);
    for (int i = 0; i < 4; i++) wp(OFS_KEY_SET0 + 8'(i), 8'h11 * 8'(i + 1));
    rp(OFS_KEY_SET3, 8'h44);
    chk_bit(unlocked, 1'b1);
    @(posedge clk_sys) warm_reset <= 1'b1;
    @(posedge clk_sys) warm_reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk_bit(unlocked, 1'b0);
    rp(OFS_FAULT_MSK, 8'h00);
    wp(OFS_FAULT_MSK, 8'hFF);
    enter_key(32'h4533_2211);
    chk_bit(unlocked, 1'b0);
    enter_key(32'h4433_2211);
    chk_bit(unlocked, 1'b1);
    rp(OFS_FAULT_MSK, 8'h41);
    // A write offered while the clock enable is low must not be taken.
    clk_en <= 1'b0;
    wp(OFS_FAULT_MSK, 8'h00);
    clk_en <= 1'b1;
    rp(OFS_FAULT_MSK, 8'h41);
    wp(OFS_CAL0, 8'h08);
    // A reset keeps the backed bytes and clears calibration control.
    @(posedge clk_sys) reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk_bit(unlocked, 1'b0);
    enter_key(32'h4433_2211);
    rp(OFS_FAULT_MSK, 8'h41);
    rp(OFS_KEY_SET0, 8'h11);
    rp(OFS_CAL0, 8'h00);
    give_verdict();
  end
endmodule // tb_fault_mask_unlock_regs
